// ### design/touch_mcu_pin_function_mux.sv
// Purpose: Pin function mux and pad configuration for a touch controller.
// Assumes: APB slave, zero wait states, pads sampled through synchronisers.
// Notes: Pads idle high after reset so reset pin reads released.
// Behaviour
// - Touch line beats port bit on touch pins
// - Port7_bit2 order: touch, pulse width, port
// - Active shield beats port bit on port7_bit6
// - Port8_bit0 order: reset, second irq, port
// - First irq beats port bit on port6_bit0
// - Irq edge chosen by edge select bits
// - Low reset pin holds controller in reset
// - Ports five to seven: pulls, open drain
// - Port eight: pull-down only
// - All ports offer high sink drive
// - Pin change wakes and raises interrupt
`include "pin_mux_consts.svh"

module touch_mcu_pin_function_mux (
  input wire logic CLK,
  input wire logic RST,
  input wire pin_mux_pkg::apb_req_s APB_REQ,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire pin_mux_pkg::pin_vec_t PAD_IN,
  output pin_mux_pkg::pad_ctrl_s PAD_CTRL,
  input wire logic [8:0] TOUCH_ACTIVE,
  input wire logic PWM_LEVEL,
  input wire logic SHIELD_LEVEL,
  output logic CORE_RESET,
  output logic WAKE,
  output logic IRQ
);
  import pin_mux_pkg::*;

  pin_vec_t data_out_q;
  pin_vec_t dir_q;
  pin_vec_t pull_up_q;
  pin_vec_t pull_down_q;
  pin_vec_t open_drain_q;
  pin_vec_t high_sink_q;
  pin_vec_t wake_en_q;
  logic [`FN_WIDTH-1:0] func_q;
  logic [1:0] edge_q;
  logic [`IRQ_WIDTH-1:0] status_q;
  logic [`IRQ_WIDTH-1:0] status_d;
  logic [`IRQ_WIDTH-1:0] irq_en_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic [31:0] rdata_d;
  logic err_d;
  logic setup;
  logic wr;
  pin_vec_t pin_level;
  pin_vec_t pin_rise;
  pin_vec_t pin_fall;
  pin_vec_t touch_pin;
  pad_owner_e owner [`NUM_PINS];
  pad_ctrl_s pad_d;
  pad_ctrl_s pad_q;
  logic ext0_evt;
  logic ext1_evt;
  logic change_evt;
  logic core_reset_q;

  // Bus phases; writes land in the access cycle
  assign setup = APB_REQ.psel & ~APB_REQ.penable;
  assign wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
  assign PREADY = 1'b1;
  assign PRDATA = rdata_q;
  assign PSLVERR = err_q & APB_REQ.psel & APB_REQ.penable;

  // One synchroniser per pad
  for (genvar i = 0; i < `NUM_PINS; i++) begin : g_sync
    pin_sync_edge u_sync (
      .clk(CLK),
      .rst(RST),
      .pad_in(PAD_IN[i]),
      .level(pin_level[i]),
      .rise(pin_rise[i]),
      .fall(pin_fall[i])
    );
  end

  // Touch line to pad map, line 8 sits on port7_bit2
  always_comb begin
    touch_pin = '0;
    touch_pin[`PIN_P5B0] = func_q[`FN_TOUCH_LSB] & TOUCH_ACTIVE[0];
    touch_pin[`PIN_P5B1] = func_q[`FN_TOUCH_LSB + 1] & TOUCH_ACTIVE[1];
    touch_pin[`PIN_P5B2] = func_q[`FN_TOUCH_LSB + 2] & TOUCH_ACTIVE[2];
    touch_pin[`PIN_P6B2] = func_q[`FN_TOUCH_LSB + 3] & TOUCH_ACTIVE[3];
    touch_pin[`PIN_P6B3] = func_q[`FN_TOUCH_LSB + 4] & TOUCH_ACTIVE[4];
    touch_pin[`PIN_P6B4] = func_q[`FN_TOUCH_LSB + 5] & TOUCH_ACTIVE[5];
    touch_pin[`PIN_P6B5] = func_q[`FN_TOUCH_LSB + 6] & TOUCH_ACTIVE[6];
    touch_pin[`PIN_P6B6] = func_q[`FN_TOUCH_LSB + 7] & TOUCH_ACTIVE[7];
    touch_pin[`PIN_P7B2] = func_q[`FN_TOUCH_LSB + 8] & TOUCH_ACTIVE[8];
  end

  // Owner of each pad by fixed priority; disabled ones fall through
  always_comb begin
    for (int i = 0; i < `NUM_PINS; i++) begin
      if (touch_pin[i]) begin
        owner[i] = OWN_TOUCH;
      end else begin
        owner[i] = OWN_GPIO;
      end
    end
    if (touch_pin[`PIN_P7B2]) begin
      owner[`PIN_P7B2] = OWN_TOUCH;
    end else if (func_q[`FN_PWM_BIT]) begin
      owner[`PIN_P7B2] = OWN_PWM;
    end else begin
      owner[`PIN_P7B2] = OWN_GPIO;
    end
    if (func_q[`FN_SHIELD_BIT]) begin
      owner[`PIN_P7B6] = OWN_SHIELD;
    end
    if (func_q[`FN_IRQ0_BIT]) begin
      owner[`PIN_P6B0] = OWN_IRQ;
    end
    if (func_q[`FN_RESET_BIT]) begin
      owner[`PIN_P8B0] = OWN_RESET;
    end else if (func_q[`FN_IRQ1_BIT]) begin
      owner[`PIN_P8B0] = OWN_IRQ;
    end else begin
      owner[`PIN_P8B0] = OWN_GPIO;
    end
  end

  // Pad controls from the owner; analog users get no pulls
  always_comb begin
    pad_d = '0;
    for (int i = 0; i < `NUM_PINS; i++) begin
      pad_d.high_sink[i] = high_sink_q[i];
      case (owner[i])
        OWN_GPIO: begin
          // Open drain drives low only, releases for a one
          pad_d.out[i] = data_out_q[i] & ~open_drain_q[i];
          pad_d.oe[i] = ~dir_q[i] & ~(open_drain_q[i] & data_out_q[i]);
          pad_d.pull_up[i] = pull_up_q[i];
          pad_d.pull_down[i] = pull_down_q[i];
        end
        OWN_TOUCH: begin
          pad_d.analog[i] = 1'b1;
        end
        OWN_PWM: begin
          pad_d.out[i] = PWM_LEVEL;
          pad_d.oe[i] = 1'b1;
        end
        OWN_SHIELD: begin
          pad_d.out[i] = SHIELD_LEVEL;
          pad_d.oe[i] = 1'b1;
        end
        OWN_IRQ: begin
          // Input only, pulls still honoured
          pad_d.pull_up[i] = pull_up_q[i];
          pad_d.pull_down[i] = pull_down_q[i];
        end
        OWN_RESET: begin
          pad_d.pull_down[i] = 1'b0;
        end
        default: begin
          pad_d.oe[i] = 1'b0;
        end
      endcase
    end
  end

  // Pad controls leave through flops to keep them glitch free
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad_d;
    end
  end
  assign PAD_CTRL = pad_q;

  // Controller reset while the shared pin reads low
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      core_reset_q <= 1'b1;
    end else begin
      core_reset_q <= func_q[`FN_RESET_BIT] & ~pin_level[`PIN_P8B0];
    end
  end
  assign CORE_RESET = core_reset_q;

  // External irq edges picked by edge select
  assign ext0_evt = (owner[`PIN_P6B0] == OWN_IRQ) &
    (edge_q[`EDGE_IRQ0_BIT] ? pin_rise[`PIN_P6B0] : pin_fall[`PIN_P6B0]);
  assign ext1_evt = (owner[`PIN_P8B0] == OWN_IRQ) &
    (edge_q[`EDGE_IRQ1_BIT] ? pin_rise[`PIN_P8B0] : pin_fall[`PIN_P8B0]);

  // Any level change on a wake-enabled pad
  assign change_evt = |(wake_en_q & (pin_rise | pin_fall));

  // Sticky status; a same-cycle event beats the clear
  always_comb begin
    status_d = status_q;
    if (wr && APB_REQ.paddr == `OFS_IRQ_CLEAR) begin
      status_d = status_q & ~APB_REQ.pwdata[`IRQ_WIDTH-1:0];
    end
    status_d[`IRQ_EXT0_BIT] = status_d[`IRQ_EXT0_BIT] | ext0_evt;
    status_d[`IRQ_EXT1_BIT] = status_d[`IRQ_EXT1_BIT] | ext1_evt;
    status_d[`IRQ_CHANGE_BIT] = status_d[`IRQ_CHANGE_BIT] | change_evt;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // Level interrupt and wake request
  assign IRQ = |(status_q & irq_en_q);
  assign WAKE = status_q[`IRQ_CHANGE_BIT];

  // Port data, direction and drive options
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      data_out_q <= `RST_ZERO13;
      dir_q <= `RST_DIR;
      high_sink_q <= `RST_ZERO13;
    end else if (wr) begin
      if (APB_REQ.paddr == `OFS_DATA_OUT) begin
        data_out_q <= APB_REQ.pwdata[12:0];
      end else if (APB_REQ.paddr == `OFS_DIR) begin
        dir_q <= APB_REQ.pwdata[12:0];
      end else if (APB_REQ.paddr == `OFS_HIGH_SINK) begin
        high_sink_q <= APB_REQ.pwdata[12:0];
      end
    end
  end

  // Pull and open drain options; port eight pull-up and open-drain bits are hardwired off
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pull_up_q <= `RST_ZERO13;
      pull_down_q <= `RST_ZERO13;
      open_drain_q <= `RST_ZERO13;
    end else if (wr) begin
      if (APB_REQ.paddr == `OFS_PULL_UP) begin
        pull_up_q <= APB_REQ.pwdata[12:0] & `MASK_NO_P8;
      end else if (APB_REQ.paddr == `OFS_PULL_DOWN) begin
        pull_down_q <= APB_REQ.pwdata[12:0];
      end else if (APB_REQ.paddr == `OFS_OPEN_DRAIN) begin
        open_drain_q <= APB_REQ.pwdata[12:0] & `MASK_NO_P8;
      end
    end
  end

  // Function enables, edge select, wake and irq enables
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      func_q <= `RST_FUNC;
      edge_q <= 2'h0;
      wake_en_q <= `RST_ZERO13;
      irq_en_q <= 3'h0;
    end else if (wr) begin
      if (APB_REQ.paddr == `OFS_FUNC_EN) begin
        func_q <= APB_REQ.pwdata[`FN_WIDTH-1:0];
      end else if (APB_REQ.paddr == `OFS_EDGE_SEL) begin
        edge_q <= APB_REQ.pwdata[1:0];
      end else if (APB_REQ.paddr == `OFS_WAKE_EN) begin
        wake_en_q <= APB_REQ.pwdata[12:0];
      end else if (APB_REQ.paddr == `OFS_IRQ_ENABLE) begin
        irq_en_q <= APB_REQ.pwdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // Read mux, evaluated in the setup cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (APB_REQ.paddr == `OFS_DATA_OUT) begin
      rdata_d[12:0] = data_out_q;
    end else if (APB_REQ.paddr == `OFS_DIR) begin
      rdata_d[12:0] = dir_q;
    end else if (APB_REQ.paddr == `OFS_PULL_UP) begin
      rdata_d[12:0] = pull_up_q;
    end else if (APB_REQ.paddr == `OFS_PULL_DOWN) begin
      rdata_d[12:0] = pull_down_q;
    end else if (APB_REQ.paddr == `OFS_OPEN_DRAIN) begin
      rdata_d[12:0] = open_drain_q;
    end else if (APB_REQ.paddr == `OFS_HIGH_SINK) begin
      rdata_d[12:0] = high_sink_q;
    end else if (APB_REQ.paddr == `OFS_WAKE_EN) begin
      rdata_d[12:0] = wake_en_q;
    end else if (APB_REQ.paddr == `OFS_FUNC_EN) begin
      rdata_d[`FN_WIDTH-1:0] = func_q;
    end else if (APB_REQ.paddr == `OFS_EDGE_SEL) begin
      rdata_d[1:0] = edge_q;
    end else if (APB_REQ.paddr == `OFS_PIN_IN) begin
      rdata_d[12:0] = pin_level;
    end else if (APB_REQ.paddr == `OFS_IRQ_STATUS) begin
      rdata_d[`IRQ_WIDTH-1:0] = status_q;
    end else if (APB_REQ.paddr == `OFS_IRQ_CLEAR) begin
      rdata_d = 32'h0000_0000; // Write-only, reads zero
    end else if (APB_REQ.paddr == `OFS_IRQ_ENABLE) begin
      rdata_d[`IRQ_WIDTH-1:0] = irq_en_q;
    end else begin
      err_d = 1'b1; // Unmapped address
    end
  end

  // Read data and error captured at setup, shown in access
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      rdata_q <= APB_REQ.pwrite ? 32'h0000_0000 : rdata_d;
      err_q <= err_d;
    end
  end

endmodule

// ### design/pin_mux_consts.svh
// Purpose: Offsets, field positions, reset values and masks of the pin mux.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Pin vector order is fixed by the PIN_* indices below.
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// Pin count and touch line count
`define NUM_PINS 13
`define NUM_TOUCH 9

// Pin indices inside every 13-bit pin vector
`define PIN_P5B0 0
`define PIN_P5B1 1
`define PIN_P5B2 2
`define PIN_P6B0 3
`define PIN_P6B2 4
`define PIN_P6B3 5
`define PIN_P6B4 6
`define PIN_P6B5 7
`define PIN_P6B6 8
`define PIN_P7B2 9
`define PIN_P7B6 10
`define PIN_P7B7 11
`define PIN_P8B0 12

// Register byte offsets
`define OFS_DATA_OUT 8'h00
`define OFS_DIR 8'h04
`define OFS_PULL_UP 8'h08
`define OFS_PULL_DOWN 8'h0C
`define OFS_OPEN_DRAIN 8'h10
`define OFS_HIGH_SINK 8'h14
`define OFS_WAKE_EN 8'h18
`define OFS_FUNC_EN 8'h1C
`define OFS_EDGE_SEL 8'h20
`define OFS_PIN_IN 8'h24
`define OFS_IRQ_STATUS 8'h28
`define OFS_IRQ_CLEAR 8'h2C
`define OFS_IRQ_ENABLE 8'h30

// Function enable fields
`define FN_TOUCH_LSB 0
`define FN_PWM_BIT 9
`define FN_SHIELD_BIT 10
`define FN_IRQ0_BIT 11
`define FN_IRQ1_BIT 12
`define FN_RESET_BIT 13
`define FN_WIDTH 14

// Edge select fields, 1 selects the rising edge
`define EDGE_IRQ0_BIT 0
`define EDGE_IRQ1_BIT 1

// Interrupt status fields
`define IRQ_EXT0_BIT 0
`define IRQ_EXT1_BIT 1
`define IRQ_CHANGE_BIT 2
`define IRQ_WIDTH 3

// Reset values
`define RST_DIR 13'h1FFF
`define RST_FUNC 14'h2000
`define RST_ZERO13 13'h0000

// Port eight has neither pull-up nor open drain
`define MASK_NO_P8 13'h0FFF

`endif

// ### design/pin_mux_pkg.sv
// Purpose: Types shared by the pin mux files.
// Assumes: Pin vectors are 13 bits wide.
// Notes: Pad controls travel together as one struct.
package pin_mux_pkg;

  typedef logic [12:0] pin_vec_t;

  // Owner of a pad
  typedef enum logic [2:0] {
    OWN_GPIO,
    OWN_TOUCH,
    OWN_PWM,
    OWN_SHIELD,
    OWN_IRQ,
    OWN_RESET
  } pad_owner_e;

  // Controls handed to the pad ring
  typedef struct packed {
    pin_vec_t out;
    pin_vec_t oe;
    pin_vec_t pull_up;
    pin_vec_t pull_down;
    pin_vec_t high_sink;
    pin_vec_t analog;
  } pad_ctrl_s;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

// ### design/pin_sync_edge.sv
// Purpose: Two-flop synchroniser with edge detect for one pad input.
// Assumes: Pad level is asynchronous to CLK.
// Notes: The first flop feeds only the second one.
module pin_sync_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic pad_in,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Synchroniser chain, prev holds last clean level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pad_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges seen on the clean level only
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule

// ### bench/pin_mux_checker.sv
// Purpose: Port-level checks of pad ownership and the reset pin.
// Assumes: Pad controls lag their cause by one clock.
// Notes: A shadow of APB writes stands in for the hidden registers.
`include "pin_mux_consts.svh"
module pin_mux_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire pin_mux_pkg::apb_req_s APB_REQ,
  input wire pin_mux_pkg::pin_vec_t PAD_IN,
  input wire pin_mux_pkg::pad_ctrl_s PAD_CTRL,
  input wire logic [8:0] TOUCH_ACTIVE,
  input wire logic PWM_LEVEL,
  input wire logic SHIELD_LEVEL,
  input wire logic CORE_RESET
);
  import pin_mux_pkg::*;
  logic [13:0] fn_q;
  pin_vec_t dir_q, dout_q, od_q;
  logic wr;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Shadow written on the same edge as the real registers
  assign wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fn_q <= `RST_FUNC;
      dir_q <= `RST_DIR;
      dout_q <= `RST_ZERO13;
      od_q <= `RST_ZERO13;
    end else if (wr) begin
      case (APB_REQ.paddr)
        `OFS_FUNC_EN: fn_q <= APB_REQ.pwdata[13:0];
        `OFS_DIR: dir_q <= APB_REQ.pwdata[12:0];
        `OFS_DATA_OUT: dout_q <= APB_REQ.pwdata[12:0];
        `OFS_OPEN_DRAIN: od_q <= APB_REQ.pwdata[12:0];
        default: ;
      endcase
    end
  end
  a_touch_first: assert property (fn_q[1] && TOUCH_ACTIVE[1] |=> PAD_CTRL.analog[1])
    else $error("touch line lost pad");
  a_touch_needs: assert property (!(fn_q[0] && TOUCH_ACTIVE[0]) |=> !PAD_CTRL.analog[0])
    else $error("idle touch kept pad");
  a_pwm_second: assert property (fn_q[9] && !dir_q[9] && !(fn_q[8] && TOUCH_ACTIVE[8])
    |=> PAD_CTRL.oe[9] && PAD_CTRL.out[9] == $past(PWM_LEVEL))
    else $error("pulse width not on pad");
  a_shield_wins: assert property (fn_q[10] && !dir_q[10]
    |=> PAD_CTRL.oe[10] && PAD_CTRL.out[10] == $past(SHIELD_LEVEL))
    else $error("shield not on pad");
  a_gpio_last: assert property (!(fn_q[2] && TOUCH_ACTIVE[2]) && !dir_q[2] && !od_q[2]
    |=> PAD_CTRL.oe[2] && PAD_CTRL.out[2] == $past(dout_q[2]))
    else $error("port bit not on pad");
  a_irq_input: assert property (fn_q[11] |=> !PAD_CTRL.oe[3])
    else $error("irq pad driven");
  a_reset_hold: assert property (fn_q[13] && !PAD_IN[12] ##1 !PAD_IN[12] [*2] |=> CORE_RESET)
    else $error("low reset pin ignored");
  a_p8_no_pull: assert property (!PAD_CTRL.pull_up[12])
    else $error("port eight pull-up");
  c_touch: cover property (PAD_CTRL.analog[9]);
  c_pwm: cover property (fn_q[9] && PAD_CTRL.oe[9]);
  c_reset: cover property ($rose(CORE_RESET));
endmodule

// ### bench/pad_model.sv
// Purpose: External pads, electrodes and programming writer.
// Assumes: Pad level settles within one clock.
// Notes: An undriven pad without pulls wanders every cycle.
module pad_model (
  input wire logic clk,
  input wire pin_mux_pkg::pad_ctrl_s ctrl,
  input wire pin_mux_pkg::pin_vec_t ext_en,
  input wire pin_mux_pkg::pin_vec_t ext_val,
  output pin_mux_pkg::pin_vec_t pad
);
  import pin_mux_pkg::*;
  initial pad = '1;
  // Resolve each wire from every driver
  always @(posedge clk) begin
    for (int i = 0; i < 13; i++) begin
      if (ctrl.oe[i])
        pad[i] <= ctrl.out[i];
      else if (ext_en[i])
        pad[i] <= ext_val[i]; // Writer clock and data
      else if (ctrl.pull_up[i])
        pad[i] <= 1'b1;
      else if (ctrl.pull_down[i])
        pad[i] <= 1'b0;
      else
        pad[i] <= ~pad[i];
    end
  end
endmodule

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the pin function mux.
// Assumes: Zero-wait APB; pads come from pad_model.
// Notes: Expectations are rebuilt from the pin map.
`include "pin_mux_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_mux_pkg::*;
  localparam int PMAP [9] = '{0, 1, 2, 4, 5, 6, 7, 8, 9};
  localparam logic [7:0] OADR [4] = '{8'h08, 8'h0C, 8'h10, 8'h14};
  localparam pin_vec_t OEXP [4] = '{`MASK_NO_P8, `RST_DIR, `MASK_NO_P8, `RST_DIR};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwm = 1'b0;
  logic shield = 1'b0;
  logic [8:0] touch = '0;
  apb_req_s req = '0;
  pin_vec_t ext_val = '1;
  pin_vec_t pad_in, an, oe, dout, o;
  pad_ctrl_s pad_ctrl;
  logic [31:0] prdata, rd;
  logic pready, pslverr, core_reset, wake, irq, err, hit;
  logic [13:0] fn;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  touch_mcu_pin_function_mux u_dut (
    .CLK(clk), .RST(rst), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PAD_IN(pad_in), .PAD_CTRL(pad_ctrl), .TOUCH_ACTIVE(touch),
    .PWM_LEVEL(pwm), .SHIELD_LEVEL(shield), .CORE_RESET(core_reset), .WAKE(wake), .IRQ(irq)
  );
  pad_model u_pads (.clk(clk), .ctrl(pad_ctrl), .ext_en(13'h1fff), .ext_val(ext_val),
    .pad(pad_in));
  initial begin
    forever #25 clk = ~clk;
  end
  // Hang guard; the run needs far fewer cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One transfer; an idle edge first so no signal is set twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    // Ends on pready; only the hang guard ends a wait that stalls
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  function automatic pin_vec_t tmap(input logic [8:0] t);
    pin_vec_t v;
    v = '0;
    for (int k = 0; k < 9; k++)
      v[PMAP[k]] = t[k];
    return v;
  endfunction
  initial begin
    void'($urandom(32'hacd2_3f84));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `OFS_FUNC_EN, '0);
    chk("func_rst", rd, 32'(`RST_FUNC));
    chk("core_reset", 32'(core_reset), 32'h0);
    apb(1'b0, 8'h3C, '0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    foreach (OADR[i]) begin
      apb(1'b1, OADR[i], 32'hffff_ffff);
      apb(1'b0, OADR[i], '0);
      chk("pad_opt", rd, 32'(OEXP[i]));
    end
    chk("pull_up", 32'(pad_ctrl.pull_up), 32'(`MASK_NO_P8));
    chk("pull_down", 32'(pad_ctrl.pull_down), 32'h0fff);
    chk("sink", 32'(pad_ctrl.high_sink[11:0]), 32'h0fff);
    foreach (OADR[i])
      apb(1'b1, OADR[i], '0);
    $display("test options done");
    // Random owners; first two rounds put pulse width under touch both ways
    apb(1'b1, `OFS_DIR, '0);
    for (int i = 0; i < 16; i++) begin
      fn = {1'b1, 13'($urandom)};
      if (i < 2)
        fn = 14'h3f00;
      dout = 13'($urandom);
      touch <= (i < 2) ? {i[0], 8'h00} : 9'($urandom);
      pwm <= 1'($urandom);
      shield <= 1'($urandom);
      apb(1'b1, `OFS_FUNC_EN, 32'(fn));
      apb(1'b1, `OFS_DATA_OUT, 32'(dout));
      repeat (2) @(posedge clk);
      an = tmap(fn[8:0] & touch);
      oe = ~an & ~(13'(fn[11]) << 3) & `MASK_NO_P8;
      o = dout;
      if (fn[9])
        o[9] = pwm;
      if (fn[10])
        o[10] = shield;
      chk("analog", 32'(pad_ctrl.analog), 32'(an));
      chk("drive", 32'(pad_ctrl.oe), 32'(oe));
      chk("level", 32'(pad_ctrl.out & oe), 32'(o & oe));
    end
    $display("test owners done");
    // Both edges under both selects; reset off gives pin 12 to irq
    apb(1'b1, `OFS_DIR, 32'(`RST_DIR));
    apb(1'b1, `OFS_FUNC_EN, 32'h1800);
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h3);
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, `OFS_EDGE_SEL, {30'h0, e[1], e[1]});
      apb(1'b1, `OFS_IRQ_CLEAR, 32'h7);
      ext_val <= {e[0], 8'hff, e[0], 3'h7};
      repeat (6) @(posedge clk);
      apb(1'b0, `OFS_IRQ_STATUS, '0);
      hit = (e[0] == e[1]);
      chk("status", rd, {30'h0, hit, hit});
      chk("irq", 32'(irq), 32'(hit));
      chk("no_reset", 32'(core_reset), 32'h0);
    end
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h4);
    @(posedge clk);
    chk("masked", 32'(irq), 32'h0);
    apb(1'b1, `OFS_WAKE_EN, 32'h0020);
    ext_val[5] <= 1'b0;
    repeat (6) @(posedge clk);
    chk("wake", 32'({wake, irq}), 32'h3);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h7);
    apb(1'b0, `OFS_IRQ_STATUS, '0);
    chk("cleared", {rd[30:0], wake}, 32'h0);
    $display("test irq done");
    apb(1'b1, `OFS_FUNC_EN, 32'(`RST_FUNC));
    ext_val[12] <= 1'b0;
    repeat (5) @(posedge clk);
    chk("core_reset", 32'(core_reset), 32'h1);
    ext_val[12] <= 1'b1;
    repeat (5) @(posedge clk);
    chk("core_reset", 32'(core_reset), 32'h0);
    $display("test reset pin done");
    finish_test();
  end
endmodule
bind touch_mcu_pin_function_mux pin_mux_checker u_chk (
  .CLK, .RST, .APB_REQ, .PAD_IN, .PAD_CTRL, .TOUCH_ACTIVE, .PWM_LEVEL, .SHIELD_LEVEL,
  .CORE_RESET
);
